// >>> design/cib_bus_sequencer.sv
// Bus sequencer for inherent and relative instructions of an 8-bit core.
// Contract
// - Register-only inherent ops take 2 reads: opcode, then opcode address plus one.
// - Add-B-to-index and double shifts: opcode, ignored read, dummy read at FFFF.
// - Stack pointer up/down: opcode, next opcode, read at old stack pointer.
// - Index up/down and index-to-stack: opcode, next opcode, dummy read FFFF.
// - Accumulator push: third cycle writes accumulator at stack pointer.
// - Accumulator pull: 4 cycles, last reads stack pointer plus one into accumulator.
// - Index push: 4 cycles, writes low byte at SP, high at SP-1.
// - Index pull: 5 cycles, high byte from SP+1, low from SP+2.
// - Subroutine return: 5 cycles, return high from SP+1, low from SP+2.
// - Wait: 9 cycles, seven stacking writes SP down to SP-6 in order.
// - Multiply: 10 cycles, opcode, ignored read, eight dummy reads at FFFF.
// - Interrupt return: 10 cycles, restore seven bytes from SP+1 to SP+7.
// - Software trap: 12 cycles, stacking, ignored write SP-7, vector FFFA/FFFB.
// - Every branch takes 3 cycles: opcode, offset, dummy read FFFF.
// - Relative call: 6 cycles, offset, FFFF, target read, return pushes.
// - One listed cycle equals one clock period of this block.
`timescale 1ns/1ps
`include "cib_params.svh"
module cib_bus_sequencer
	import cib_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  data_in,
	output logic      [15:0] addr,
	output logic             read_write,
	output logic      [7:0]  data_out,
	output logic             data_oe,
	output logic             instr_start,
	output logic      [15:0] pc,
	output logic      [15:0] sp,
	output logic      [15:0] x_reg,
	output logic      [7:0]  acc_a,
	output logic      [7:0]  acc_b,
	output logic      [7:0]  ccr
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cib_state_e state, next_state;
	logic [3:0]  cyc, next_cyc;
	logic [7:0]  opc, next_opc;
	logic [7:0]  offs, next_offs;
	logic [15:0] base, next_base;
	logic [15:0] next_addr, next_pc, next_sp, next_x_reg;
	logic [7:0]  next_data_out, next_acc_a, next_acc_b, next_ccr;
	logic        next_read_write, next_data_oe, next_instr_start;
	cib_grp_e    grp;
	cib_op_e     op;
	logic [3:0]  cycles;

	// The classifier sees the latched opcode for the whole instruction.
	cib_op_decode u_dec (
		.opcode (opc),
		.grp    (grp),
		.op     (op),
		.cycles (cycles)
	);

	// Seven-byte stacking order shared by wait and software trap.
	function automatic logic [7:0] stack_byte(input logic [2:0] idx,
		input logic [15:0] ret, input logic [15:0] xv,
		input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		case (idx)
			3'd0:    stack_byte = ret[7:0];
			3'd1:    stack_byte = ret[15:8];
			3'd2:    stack_byte = xv[7:0];
			3'd3:    stack_byte = xv[15:8];
			3'd4:    stack_byte = a;
			3'd5:    stack_byte = b;
			default: stack_byte = c;
		endcase
	endfunction : stack_byte

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Each clock is one bus cycle; addr/read_write are set up one edge
	// ahead so the outputs stay pure flip-flops.
	always_comb begin
		logic [3:0] c;
		logic       last;
		c                = 4'h0;
		last             = 1'b0;
		next_state       = state;
		next_cyc         = cyc;
		next_opc         = opc;
		next_offs        = offs;
		next_base        = base;
		next_pc          = pc;
		next_sp          = sp;
		next_x_reg       = x_reg;
		next_acc_a       = acc_a;
		next_acc_b       = acc_b;
		next_ccr         = ccr;
		next_addr        = addr;
		next_read_write  = 1'b1;
		next_data_out    = 8'h00;
		next_data_oe     = 1'b0;
		next_instr_start = 1'b0;
		if (state == CIB_ST_FETCH) begin
			// Cycle 1 on the bus now: opcode read at pc.
			next_opc   = data_in;
			next_pc    = pc + 16'h0001;
			next_addr  = pc + 16'h0001; // cycle 2 at opcode address + 1
			next_cyc   = 4'h2;
			next_state = CIB_ST_EXEC;
		end else begin
			c    = cyc;
			last = (c == cycles);
			// Compute the address for cycle c+1 and capture cycle c data.
			case (grp)
				CIB_GRP_BRANCH: begin
					if (c == 4'h2) begin
						next_offs = data_in;
						next_addr = `CIB_DUMMY_ADDR;
					end else begin
						next_pc = pc + 16'h0001 + {{8{offs[7]}}, offs};
					end
				end
				CIB_GRP_BSR: begin
					case (c)
						4'h2: begin
							next_offs = data_in;
							next_pc   = pc + 16'h0001;
							next_addr = `CIB_DUMMY_ADDR;
						end
						4'h3: begin
							next_base = pc;
							next_pc   = pc + {{8{offs[7]}}, offs};
							next_addr = pc + {{8{offs[7]}}, offs};
						end
						4'h4: begin
							next_addr       = sp;
							next_read_write = 1'b0;
							next_data_out   = base[7:0];
							next_data_oe    = 1'b1;
						end
						4'h5: begin
							next_sp         = sp - 16'h0001;
							next_addr       = sp - 16'h0001;
							next_read_write = 1'b0;
							next_data_out   = base[15:8];
							next_data_oe    = 1'b1;
						end
						default: next_sp = sp - 16'h0001;
					endcase
				end
				CIB_GRP_SWI: begin
					// A one-byte trap returns to the byte after its opcode.
					if (c == 4'h2)
						next_base = pc;
					if (c >= 4'h3 && c <= 4'hA)
						next_sp = sp - 16'h0001;
					if (c >= 4'h2 && c <= 4'h8) begin
						next_addr = (c == 4'h2) ? sp : sp - 16'h0001;
						next_read_write = 1'b0;
						next_data_out = stack_byte(3'(c - 4'h2),
							(c == 4'h2) ? pc : base,
							x_reg, acc_a, acc_b, ccr);
						next_data_oe = 1'b1;
					end else if (c == 4'h9) begin
						next_addr = sp - 16'h0001;
						next_read_write = 1'b0;
						next_data_oe = 1'b1;
					end else if (c == 4'hA) begin
						next_addr = `CIB_SWI_VEC_HI;
						next_ccr = ccr | 8'h10;
					end else if (c == 4'hB) begin
						next_pc[15:8] = data_in;
						next_addr = `CIB_SWI_VEC_LO;
					end else if (c == 4'hC) begin
						next_pc[7:0] = data_in;
					end
				end
				default: begin
					case (op)
						CIB_OP_REG: ;
						CIB_OP_ABX, CIB_OP_X_FFFF, CIB_OP_MUL: begin
							if (c < 4'hA && !last)
								next_addr = `CIB_DUMMY_ADDR;
							if (last && op == CIB_OP_X_FFFF) begin
								case (opc)
									8'h08: next_x_reg = x_reg + 16'h0001;
									8'h09: next_x_reg = x_reg - 16'h0001;
									default: next_sp = x_reg - 16'h0001;
								endcase
							end
							if (last && opc == 8'h3A)
								next_x_reg = x_reg + {8'h00, acc_b};
						end
						CIB_OP_SP_INC, CIB_OP_SP_DEC, CIB_OP_TSX: begin
							if (c == 4'h2)
								next_addr = sp;
							else if (op == CIB_OP_SP_INC)
								next_sp = sp + 16'h0001;
							else if (op == CIB_OP_SP_DEC)
								next_sp = sp - 16'h0001;
							else
								next_x_reg = sp + 16'h0001;
						end
						CIB_OP_PUSH_A, CIB_OP_PUSH_B: begin
							if (c == 4'h2) begin
								next_addr = sp;
								next_read_write = 1'b0;
								next_data_out = (op == CIB_OP_PUSH_A) ? acc_a : acc_b;
								next_data_oe = 1'b1;
							end else
								next_sp = sp - 16'h0001;
						end
						CIB_OP_PUSH_X: begin
							if (c == 4'h2) begin
								next_addr = sp;
								next_read_write = 1'b0;
								next_data_out = x_reg[7:0];
								next_data_oe = 1'b1;
							end else if (c == 4'h3) begin
								next_sp = sp - 16'h0001;
								next_addr = sp - 16'h0001;
								next_read_write = 1'b0;
								next_data_out = x_reg[15:8];
								next_data_oe = 1'b1;
							end else
								next_sp = sp - 16'h0001;
						end
						default: begin // pulls, return, wait, interrupt return
							if (op == CIB_OP_WAI) begin
								if (c >= 4'h3)
									next_sp = sp - 16'h0001;
								if (c <= 4'h8) begin
									next_addr = (c == 4'h2) ? sp : sp - 16'h0001;
									next_read_write = 1'b0;
									next_data_out = stack_byte(3'(c - 4'h2),
										pc, x_reg, acc_a, acc_b, ccr);
									next_data_oe = 1'b1;
								end
							end else if (c == 4'h2) begin
								next_addr = sp;
							end else begin
								// Pre-increment before every pulled byte.
								if (!last) begin
									next_sp = sp + 16'h0001;
									next_addr = sp + 16'h0001;
								end
								if (c >= 4'h4) begin
									case (op)
										CIB_OP_PULL_A: next_acc_a = data_in;
										CIB_OP_PULL_B: next_acc_b = data_in;
										CIB_OP_PULL_X: begin
											if (c == 4'h4) next_x_reg[15:8] = data_in;
											else next_x_reg[7:0] = data_in;
										end
										CIB_OP_RTS: begin
											if (c == 4'h4) next_pc[15:8] = data_in;
											else next_pc[7:0] = data_in;
										end
										default: begin
											case (c)
												4'h4: next_ccr = data_in;
												4'h5: next_acc_b = data_in;
												4'h6: next_acc_a = data_in;
												4'h7: next_x_reg[15:8] = data_in;
												4'h8: next_x_reg[7:0] = data_in;
												4'h9: next_pc[15:8] = data_in;
												default: next_pc[7:0] = data_in;
											endcase
										end
									endcase
								end
							end
						end
					endcase
				end
			endcase
			next_cyc = c + 4'h1;
			if (last) begin
				// Register-only and next-opcode cases: pc already points on.
				next_addr        = next_pc;
				next_read_write  = 1'b1;
				next_data_oe     = 1'b0;
				next_state       = CIB_ST_FETCH;
				next_cyc         = 4'h1;
				next_instr_start = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state       <= CIB_ST_FETCH;
			cyc         <= 4'h1;
			opc         <= 8'h00;
			offs        <= 8'h00;
			base        <= 16'h0000;
			addr        <= `CIB_RESET_PC;
			read_write  <= 1'b1;
			data_out    <= 8'h00;
			data_oe     <= 1'b0;
			instr_start <= 1'b1;
			pc          <= `CIB_RESET_PC;
			sp          <= `CIB_RESET_SP;
			x_reg       <= 16'h0000;
			acc_a       <= 8'h00;
			acc_b       <= 8'h00;
			ccr         <= 8'h00;
		end else begin
			state       <= next_state;
			cyc         <= next_cyc;
			opc         <= next_opc;
			offs        <= next_offs;
			base        <= next_base;
			addr        <= next_addr;
			read_write  <= next_read_write;
			data_out    <= next_data_out;
			data_oe     <= next_data_oe;
			instr_start <= next_instr_start;
			pc          <= next_pc;
			sp          <= next_sp;
			x_reg       <= next_x_reg;
			acc_a       <= next_acc_a;
			acc_b       <= next_acc_b;
			ccr         <= next_ccr;
		end
	end
endmodule : cib_bus_sequencer

// >>> design/cib_params.svh
// Constants for the inherent and relative bus sequencer.
`ifndef CIB_PARAMS_SVH
`define CIB_PARAMS_SVH
`define CIB_DUMMY_ADDR   16'hFFFF
`define CIB_SWI_VEC_HI   16'hFFFA
`define CIB_SWI_VEC_LO   16'hFFFB
`define CIB_CYC_REG      4'h2
`define CIB_CYC_THREE    4'h3
`define CIB_CYC_PULL_ACC_A     4'h4
`define CIB_CYC_PUSH_X_PAIR     4'h4
`define CIB_CYC_PULL_X_PAIR     4'h5
`define CIB_CYC_RTS      4'h5
`define CIB_CYC_WAI      4'h9
`define CIB_CYC_MUL      4'hA
`define CIB_CYC_RTI      4'hA
`define CIB_CYC_SWI      4'hC
`define CIB_CYC_BSR      4'h6
`define CIB_RESET_PC     16'h0000
`define CIB_RESET_SP     16'h00FF
`endif

// >>> design/cib_pkg.sv
// Types shared by the sequencer files.
package cib_pkg;
	typedef enum logic [3:0] {
		CIB_OP_REG, CIB_OP_ABX, CIB_OP_SP_INC, CIB_OP_SP_DEC,
		CIB_OP_X_FFFF, CIB_OP_TSX, CIB_OP_PUSH_A, CIB_OP_PUSH_B,
		CIB_OP_PULL_A, CIB_OP_PULL_B, CIB_OP_PUSH_X, CIB_OP_PULL_X,
		CIB_OP_RTS, CIB_OP_WAI, CIB_OP_MUL, CIB_OP_RTI
	} cib_op_e;
	typedef enum logic [1:0] {
		CIB_GRP_INH, CIB_GRP_SWI, CIB_GRP_BRANCH, CIB_GRP_BSR
	} cib_grp_e;
	typedef enum logic {
		CIB_ST_FETCH, CIB_ST_EXEC
	} cib_state_e;
endpackage : cib_pkg

// >>> design/cib_op_decode.sv
// Opcode classifier: maps an opcode to its sequence group and length.
`timescale 1ns/1ps
`include "cib_params.svh"
module cib_op_decode
	import cib_pkg::*;
(
	input  wire logic [7:0] opcode,
	output cib_grp_e        grp,
	output cib_op_e         op,
	output logic [3:0]      cycles
);
	always_comb begin
		grp    = CIB_GRP_INH;
		op     = CIB_OP_REG;
		cycles = `CIB_CYC_REG;
		if (opcode[7:4] == 4'h2) begin
			grp    = CIB_GRP_BRANCH;
			cycles = `CIB_CYC_THREE;
		end else if (opcode == 8'h8D) begin
			grp    = CIB_GRP_BSR;
			cycles = `CIB_CYC_BSR;
		end else if (opcode == 8'h3F) begin
			grp    = CIB_GRP_SWI;
			cycles = `CIB_CYC_SWI;
		end else begin
			case (opcode)
				8'h3A, 8'h05, 8'h04: begin
					op = CIB_OP_ABX; cycles = `CIB_CYC_THREE;
				end
				8'h31: begin op = CIB_OP_SP_INC; cycles = `CIB_CYC_THREE; end
				8'h34: begin op = CIB_OP_SP_DEC; cycles = `CIB_CYC_THREE; end
				8'h08, 8'h09, 8'h35: begin
					op = CIB_OP_X_FFFF; cycles = `CIB_CYC_THREE;
				end
				8'h30: begin op = CIB_OP_TSX; cycles = `CIB_CYC_THREE; end
				8'h36: begin op = CIB_OP_PUSH_A; cycles = `CIB_CYC_THREE; end
				8'h37: begin op = CIB_OP_PUSH_B; cycles = `CIB_CYC_THREE; end
				8'h32: begin op = CIB_OP_PULL_A; cycles = `CIB_CYC_PULL_ACC_A; end
				8'h33: begin op = CIB_OP_PULL_B; cycles = `CIB_CYC_PULL_ACC_A; end
				8'h3C: begin op = CIB_OP_PUSH_X; cycles = `CIB_CYC_PUSH_X_PAIR; end
				8'h38: begin op = CIB_OP_PULL_X; cycles = `CIB_CYC_PULL_X_PAIR; end
				8'h39: begin op = CIB_OP_RTS; cycles = `CIB_CYC_RTS; end
				8'h3E: begin op = CIB_OP_WAI; cycles = `CIB_CYC_WAI; end
				8'h3D: begin op = CIB_OP_MUL; cycles = `CIB_CYC_MUL; end
				8'h3B: begin op = CIB_OP_RTI; cycles = `CIB_CYC_RTI; end
				default: begin op = CIB_OP_REG; cycles = `CIB_CYC_REG; end
			endcase
		end
	end
endmodule : cib_op_decode

// >>> bench/cib_mem_model.sv
// Zero-wait memory model standing on the sequencer's bus.
`timescale 1ns/1ps
module cib_mem_model (
	input  wire logic        mclk,
	input  wire logic [15:0] addr,
	input  wire logic        read_write,
	input  wire logic [7:0]  data_out,
	input  wire logic        data_oe,
	output logic      [7:0]  data_in
);
	logic [7:0] ram [0:65535];
	// Reads answer at once, so no cycle of the sequence ever stretches.
	assign data_in = ram[addr];
	always @(posedge mclk) begin
		if (!read_write && data_oe) begin
			ram[addr] <= data_out;
		end
	end
endmodule : cib_mem_model

// >>> bench/cib_bus_sequencer_sva.sv
// Bus timing checker for the inherent and relative sequencer.
`timescale 1ns/1ps
module cib_bus_sequencer_chk (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic [7:0]  data_in,
	input wire logic [15:0] addr,
	input wire logic        read_write,
	input wire logic        data_oe,
	input wire logic        instr_start,
	input wire logic [15:0] sp
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_reg_two: assert property (
		instr_start && data_in == 8'h01 |=> read_write &&
		addr == $past(addr) + 16'h0001 ##1 instr_start)
		else $error("register op is not two reads");
	a_dummy_read: assert property (
		instr_start && data_in inside {8'h3A, 8'h05, 8'h04, 8'h08,
		8'h09, 8'h35} |=> read_write ##1 addr == 16'hFFFF &&
		read_write ##1 instr_start)
		else $error("dummy read cycle missing");
	a_stack_old: assert property (
		instr_start && data_in inside {8'h31, 8'h34} |-> ##2
		addr == $past(sp, 2) && read_write ##1 instr_start)
		else $error("stack step read is wrong");
	a_push_acc: assert property (
		instr_start && data_in inside {8'h36, 8'h37} |-> ##2
		addr == $past(sp, 2) && !read_write && data_oe ##1
		instr_start && sp == $past(sp, 3) - 16'h0001)
		else $error("accumulator push is wrong");
	a_wai_writes: assert property (
		instr_start && data_in == 8'h3E |=> read_write ##1
		!read_write [*7] ##1 instr_start)
		else $error("wait stacking is wrong");
	a_mul_len: assert property (
		instr_start && data_in == 8'h3D |=> read_write ##1
		(addr == 16'hFFFF && read_write) [*8] ##1 instr_start)
		else $error("product op length is wrong");
	a_trap_vec: assert property (
		instr_start && data_in == 8'h3F |-> ##10 addr == 16'hFFFA &&
		read_write ##1 addr == 16'hFFFB && read_write ##1 instr_start)
		else $error("trap vector fetch is wrong");
	a_branch_three: assert property (
		instr_start && data_in[7:4] == 4'h2 |=> ##1 addr == 16'hFFFF &&
		read_write ##1 instr_start)
		else $error("branch is not three cycles");
	a_call_push: assert property (
		instr_start && data_in == 8'h8D |-> ##4 !read_write &&
		addr == $past(sp, 4) ##1 !read_write ##1 instr_start)
		else $error("relative call is wrong");
	a_oe_on_write: assert property (
		read_write != data_oe)
		else $error("drive enable disagrees with direction");
endmodule : cib_bus_sequencer_chk
bind cib_bus_sequencer cib_bus_sequencer_chk u_chk (.mclk(mclk),
	.reset_n(reset_n), .data_in(data_in), .addr(addr),
	.read_write(read_write), .data_oe(data_oe),
	.instr_start(instr_start), .sp(sp));

// >>> bench/cib_bus_sequencer_tb.sv
// Self-checking bench for the inherent and relative sequencer.
`timescale 1ns/1ps
module cib_bus_sequencer_tb;
	logic        mclk;
	logic        reset_n;
	logic [7:0]  data_in;
	logic [15:0] addr;
	logic        read_write;
	logic [7:0]  data_out;
	logic        data_oe;
	logic        instr_start;
	logic [15:0] ep, es, ex, sp_seen;
	logic [7:0]  va, vb, vc;
	bit          xk, ak, bk;
	int          err_count, tests_run, seed, k;
	logic [15:0] aq[$];
	bit          wq[$];
	logic [8:0]  dq[$];
	logic [7:0]  ops [27] = '{8'h01, 8'h00, 8'h4F, 8'h0D, 8'h3A, 8'h05,
		8'h04, 8'h31, 8'h34, 8'h08, 8'h09, 8'h30, 8'h36, 8'h37, 8'h32,
		8'h33, 8'h3C, 8'h38, 8'h39, 8'h3E, 8'h3D, 8'h3B, 8'h3F, 8'h20,
		8'h27, 8'h2E, 8'h8D};

	cib_bus_sequencer uut (.mclk(mclk), .reset_n(reset_n),
		.data_in(data_in), .addr(addr), .read_write(read_write),
		.data_out(data_out), .data_oe(data_oe),
		.instr_start(instr_start), .pc(), .sp(sp_seen), .x_reg(),
		.acc_a(),
		.acc_b(), .ccr());
	cib_mem_model u_mem (.mclk(mclk), .addr(addr),
		.read_write(read_write), .data_out(data_out), .data_oe(data_oe),
		.data_in(data_in));

	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask : chk

	task automatic add(input logic [15:0] a, input bit w,
		input logic [8:0] d);
		aq.push_back(a);
		wq.push_back(w);
		dq.push_back(d);
	endtask : add

	function automatic logic [7:0] m(input int o);
		return u_mem.ram[16'(es + o)];
	endfunction : m

	// Builds the expected cycle list from the bench's own register view.
	task automatic exec(input logic [7:0] op, input logic [7:0] b1);
		logic [15:0] a, t, r, g, pk;
		logic [8:0]  st [7];
		int          i;
		a = ep;
		t = a + 16'h0001;
		r = t + 16'h0001;
		if (op[7:4] == 4'h2 && op != 8'h20) b1 = 8'h00;
		g = r + {{8{b1[7]}}, b1};
		for (i = 1; i < 8; i++) u_mem.ram[16'(es + i)] = 8'($random(seed));
		u_mem.ram[16'(es + 1)][7:6] = 2'b01;
		u_mem.ram[16'(es + 6)][7:6] = 2'b01;
		u_mem.ram[a] = op;
		u_mem.ram[t] = b1;
		pk = {m(1), m(2)};
		st = '{{1'b1, t[7:0]}, {1'b1, t[15:8]}, {xk, ex[7:0]},
			{xk, ex[15:8]}, {ak, va}, {bk, vb}, {1'b1, vc}};
		chk("sp", es, sp_seen);
		aq.delete();
		wq.delete();
		dq.delete();
		add(a, 1, 0);
		add(t, 1, 0);
		ep = t;
		case (op) inside
		8'h3A, 8'h05, 8'h04, 8'h08, 8'h09, 8'h35: begin
			add(16'hFFFF, 1, 0);
			ex = ex + (op == 8'h08) - (op == 8'h09);
			if (op == 8'h35) es = ex - 16'h0001;
			if (op == 8'h3A) xk = 0;
			if (op < 8'h06) begin ak = 0; bk = 0; end
		end
		8'h31, 8'h34, 8'h30: begin
			add(es, 1, 0);
			if (op == 8'h30) begin
				ex = es + 16'h0001;
				xk = 1;
			end
			es = es + (op == 8'h31) - (op == 8'h34);
		end
		8'h36, 8'h37: begin
			add(es, 0, op[0] ? {bk, vb} : {ak, va});
			es = es - 16'h0001;
		end
		8'h3C: begin
			add(es, 0, st[2]);
			add(16'(es - 1), 0, st[3]);
			es = es - 16'h0002;
		end
		8'h32, 8'h33, 8'h38, 8'h39: begin
			add(es, 1, 0);
			add(16'(es + 1), 1, 0);
			if (op[3]) add(16'(es + 2), 1, 0);
			if (op == 8'h32) begin va = pk[15:8]; ak = 1; end
			if (op == 8'h33) begin vb = pk[15:8]; bk = 1; end
			if (op == 8'h38) begin ex = pk; xk = 1; end
			if (op == 8'h39) ep = pk;
			es = es + 16'h0001 + op[3];
		end
		8'h3E, 8'h3F: begin
			for (i = 0; i < 7; i++) add(16'(es - i), 0, st[i]);
			es = es - 16'h0007;
			if (op[0]) begin
				add(es, 0, 9'h100);
				add(16'hFFFA, 1, 0);
				add(16'hFFFB, 1, 0);
				es = es - 16'h0001;
				vc = vc | 8'h10;
			end
		end
		8'h3D: begin
			repeat (8) add(16'hFFFF, 1, 0);
			ak = 0;
			bk = 0;
		end
		8'h3B: begin
			for (i = 0; i < 8; i++) add(16'(es + i), 1, 0);
			vc = m(1);
			vb = m(2);
			va = m(3);
			ex = {m(4), m(5)};
			ep = {m(6), m(7)};
			{ak, bk, xk} = 3'b111;
			es = es + 16'h0007;
		end
		8'h8D: begin
			add(16'hFFFF, 1, 0);
			add(g, 1, 0);
			add(es, 0, {1'b1, r[7:0]});
			add(16'(es - 1), 0, {1'b1, r[15:8]});
			es = es - 16'h0002;
			ep = g;
		end
		default: begin
			if (op[7:4] == 4'h2) begin
				add(16'hFFFF, 1, 0);
				ep = g;
			end else begin
				ak = 0;
				bk = 0;
			end
		end
		endcase
		for (i = 0; i < aq.size(); i++) begin
			chk("addr", aq[i], addr);
			chk("read_write", wq[i], read_write);
			chk("instr_start", i == 0, instr_start);
			if (dq[i][8]) chk("data_out", dq[i][7:0], data_out);
			@(negedge mclk);
		end
		if (op == 8'h3F) ep = {u_mem.ram[16'hFFFA], u_mem.ram[16'hFFFB]};
	endtask : exec

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	initial begin
		#(5.0 * 20000);
		err_count++;
		summarize();
	end

	initial begin
		seed = 25937;
		reset_n = 1'b0;
		{ep, es, ex, va, vb} = {16'h0000, 16'h00FF, 16'h0000, 16'h0000};
		{xk, ak, bk} = 3'b111;
		vc = 8'h00;
		for (k = 0; k < 65536; k++) u_mem.ram[k] = 8'($random(seed));
		u_mem.ram[16'hFFFA] = 8'h40;
		repeat (8) @(negedge mclk);
		reset_n = 1'b1;
		exec(8'h3F, 8'h00);
		exec(8'h32, 8'h00);
		exec(8'h36, 8'h00);
		exec(8'h33, 8'h00);
		exec(8'h37, 8'h00);
		exec(8'h38, 8'h00);
		exec(8'h3C, 8'h00);
		exec(8'h3B, 8'h00);
		exec(8'h3E, 8'h00);
		for (k = 8'h20; k < 8'h30; k++) exec(8'(k), 8'h80);
		exec(8'h8D, 8'h80);
		exec(8'h20, 8'h7F);
		repeat (300) exec(ops[$unsigned($random(seed)) % 27],
			8'($random(seed)));
		exec(8'h38, 8'h00);
		exec(8'h35, 8'h00);
		exec(8'h01, 8'h00);
		summarize();
	end
endmodule : cib_bus_sequencer_tb
